/* src/amp_cfg_pkg.sv */
// Operation
// RQ1 - bit 7 selects external or internal aux supply
// RQ2 - bit 6 enables interrupt pin pull-up
// RQ3 - bit 5 spread spectrum, on after reset
// RQ4 - clock sync overrides spread spectrum
// RQ5 - 3-bit playback dc-block cutoff select
// RQ6 - 3-bit record dc-block cutoff, same encoding
// RQ7 - 44.1/88.2 kHz families scale cutoffs down
// RQ8 - thermal foldback enable, off after reset
// RQ9 - over-current auto retry enable
// RQ10 - over-temperature auto retry enable
// RQ11 - feedback from outputs or sense pins
// RQ12 - safe mode adds fixed attenuation
// RQ13 - over-current threshold lowered in 10% steps
// RQ14 - shutdown pin timed or immediate response
// RQ15 - shutdown timeout 2/4/6/23.8 ms select
// RQ16 - volume ramp step interval or disabled
// RQ17 - broadcast i2c address enable
// RQ18 - address re-detect bit self clears
// RQ19 - aux supply use depends on mode selects
// RQ20 - reserved bits read zero, reserved codes ignored; code stores written reserved bits of offsets 0x05 and 0x06
package amp_cfg_pkg;

	// register offsets
	localparam logic [7:0] OFS_PB_SUPPLY = 8'h04;
	localparam logic [7:0] OFS_REC_FOLD  = 8'h05;
	localparam logic [7:0] OFS_PROT_FB   = 8'h06;
	localparam logic [7:0] OFS_SD_VOL    = 8'h07;

	// values after reset
	localparam logic [7:0] RST_PB_SUPPLY = 8'h21;
	localparam logic [7:0] RST_REC_FOLD  = 8'h41;
	localparam logic [7:0] RST_PROT_FB   = 8'h00;
	localparam logic [7:0] RST_SD_VOL    = 8'h20;

	// field positions
	localparam int BIT_AUX_SRC     = 7;
	localparam int BIT_IRQ_PU      = 6;
	localparam int BIT_SPREAD      = 5;
	localparam int BIT_FOLDBACK    = 3;
	localparam int BIT_OC_RETRY    = 5;
	localparam int BIT_OT_RETRY    = 4;
	localparam int BIT_PF_FB       = 3;
	localparam int BIT_SAFE_ATTN   = 2;
	localparam int BIT_BCAST       = 1;
	localparam int BIT_REDETECT    = 0;
	localparam int POS_CUTOFF      = 0;
	localparam int POS_OC_THR      = 0;
	localparam int POS_SD_RESP     = 6;
	localparam int POS_SD_TMO      = 4;
	localparam int POS_RAMP        = 2;
	localparam int POS_REC_RSVD    = 4;
	localparam int POS_PROT_RSVD   = 6;

	// field encodings, with the reserved cutoff code
	localparam logic [2:0] CUTOFF_RSVD      = 3'h7;
	localparam logic [1:0] SD_RESP_TIMED    = 2'h0;
	localparam logic [1:0] SD_RESP_FORCED   = 2'h1;
	localparam logic [1:0] RAMP_OFF         = 2'h3;
	localparam logic [1:0] SWMODE_HV_ONLY   = 2'h2;

	// fixed gain figures
	localparam logic [4:0] SAFE_ATTN_DB     = 5'h12;
	localparam logic [15:0] SCALE_UNITY_Q14 = 16'h4000;
	localparam logic [15:0] SCALE_441_Q14   = 16'h3acd;

	// shutdown timeouts in ms and their cycle counts
	localparam real CLK_MHZ   = 250.0;
	localparam real T_SD0_MS  = 2.0;
	localparam real T_SD1_MS  = 4.0;
	localparam real T_SD2_MS  = 6.0;
	localparam real T_SD3_MS  = 23.8;
	localparam int  CYC_SD0   = $rtoi(T_SD0_MS * 1000.0 * CLK_MHZ);
	localparam int  CYC_SD1   = $rtoi(T_SD1_MS * 1000.0 * CLK_MHZ);
	localparam int  CYC_SD2   = $rtoi(T_SD2_MS * 1000.0 * CLK_MHZ);
	localparam int  CYC_SD3   = $rtoi(T_SD3_MS * 1000.0 * CLK_MHZ);
	localparam int  TMO_W     = 23;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		SD_RUN  = 2'b00,
		SD_WAIT = 2'b01,
		SD_OFF  = 2'b10
	} sd_state_t;

endpackage : amp_cfg_pkg

/* src/amp_cfg_pkg_note_unused.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* src/amp_dc_block_misc_config.sv */
`timescale 1ns/1ps
`default_nettype none
module amp_dc_block_misc_config #(
	parameter int P_CYC_SD0 = amp_cfg_pkg::CYC_SD0,
	parameter int P_CYC_SD1 = amp_cfg_pkg::CYC_SD1,
	parameter int P_CYC_SD2 = amp_cfg_pkg::CYC_SD2,
	parameter int P_CYC_SD3 = amp_cfg_pkg::CYC_SD3
) (
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_rst,
	input  wire amp_cfg_pkg::reg_req_t i_reg_req,
	input  wire logic                 i_classd_sync_en,
	input  wire logic                 i_rate_441_family,
	input  wire logic [1:0]           i_switch_mode,
	input  wire logic                 i_brownout_src_hv,
	input  wire logic                 i_shutdown_pin_n,
	input  wire logic                 i_address_detect_done,
	output logic [7:0]                o_reg_rdata,
	output logic                      o_aux_supply_internal,
	output logic                      o_aux_feeds_output_stage,
	output logic                      o_aux_is_brownout_src,
	output logic                      o_irq_pin_pullup_en,
	output logic                      o_spread_spectrum_active,
	output logic [9:0]                o_playback_cutoff_hz,
	output logic [9:0]                o_record_cutoff_hz,
	output logic [15:0]               o_cutoff_scale_q14,
	output logic                      o_thermal_foldback_en,
	output logic                      o_overcurrent_auto_retry,
	output logic                      o_overtemp_auto_retry,
	output logic                      o_post_filter_feedback_en,
	output logic [4:0]                o_extra_attenuation_db,
	output logic [4:0]                o_overcurrent_threshold_below_pct,
	output logic                      o_shutdown_req,
	output logic [3:0]                o_volume_ramp_samples,
	output logic                      o_volume_ramp_disabled,
	output logic                      o_broadcast_address_en,
	output logic                      o_target_address_redetect
);

	// cutoff code to nominal corner in hz; bypass and reserved give zero
	function automatic logic [9:0] cutoff_hz(input logic [2:0] code);
		logic [9:0] hz;
		hz = 10'h000;
		case (code)
			3'h1: hz = 10'h002;
			3'h2: hz = 10'h032;
			3'h3: hz = 10'h064;
			3'h4: hz = 10'h0c8;
			3'h5: hz = 10'h190;
			3'h6: hz = 10'h320;
			default: hz = 10'h000;
		endcase
		return hz;
	endfunction : cutoff_hz

	logic [7:0]  pb_r, pb_nxt;
	logic [7:0]  rec_r, rec_nxt;
	logic [7:0]  prot_r, prot_nxt;
	logic [7:0]  sd_r, sd_nxt;
	logic [7:0]  rdata_nxt;
	logic        wr_pb, wr_rec, wr_prot, wr_sd;

	assign wr_pb   = i_reg_req.wr && (i_reg_req.addr == amp_cfg_pkg::OFS_PB_SUPPLY);
	assign wr_rec  = i_reg_req.wr && (i_reg_req.addr == amp_cfg_pkg::OFS_REC_FOLD);
	assign wr_prot = i_reg_req.wr && (i_reg_req.addr == amp_cfg_pkg::OFS_PROT_FB);
	assign wr_sd   = i_reg_req.wr && (i_reg_req.addr == amp_cfg_pkg::OFS_SD_VOL);

	// register file next state; reserved codes keep the previous field so behaviour holds
	always_comb begin
		pb_nxt   = pb_r;
		rec_nxt  = rec_r;
		prot_nxt = prot_r;
		sd_nxt   = sd_r;
		if (wr_pb) begin
			// RQ1 RQ2 RQ3 control bits
			pb_nxt[7:5] = i_reg_req.wdata[7:5];
			// RQ5 playback cutoff code
			if (i_reg_req.wdata[2:0] != amp_cfg_pkg::CUTOFF_RSVD) begin
				pb_nxt[2:0] = i_reg_req.wdata[2:0];
			end
		end
		if (wr_rec) begin
			// RQ8 foldback and reserved storage
			rec_nxt[7:3] = i_reg_req.wdata[7:3];
			// RQ6 record cutoff code
			if (i_reg_req.wdata[2:0] != amp_cfg_pkg::CUTOFF_RSVD) begin
				rec_nxt[2:0] = i_reg_req.wdata[2:0];
			end
		end
		if (wr_prot) begin
			// RQ9 RQ10 RQ11 RQ12 RQ13 all plain fields
			prot_nxt = i_reg_req.wdata;
		end
		if (wr_sd) begin
			// RQ14 reserved response codes ignored
			if (i_reg_req.wdata[7] == 1'b0) begin
				sd_nxt[7:6] = i_reg_req.wdata[7:6];
			end
			// RQ15 RQ16 RQ17 plain fields
			sd_nxt[5:1] = i_reg_req.wdata[5:1];
		end
		// RQ18 self clearing, a new write wins over completion
		if (wr_sd && i_reg_req.wdata[amp_cfg_pkg::BIT_REDETECT]) begin
			sd_nxt[amp_cfg_pkg::BIT_REDETECT] = 1'b1;
		end else if (i_address_detect_done) begin
			sd_nxt[amp_cfg_pkg::BIT_REDETECT] = 1'b0;
		end
		// RQ20 read-only reserved bits stay zero
		pb_nxt[4:3] = 2'b00;
	end

	// register file storage
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			pb_r   <= amp_cfg_pkg::RST_PB_SUPPLY;
			rec_r  <= amp_cfg_pkg::RST_REC_FOLD;
			prot_r <= amp_cfg_pkg::RST_PROT_FB;
			sd_r   <= amp_cfg_pkg::RST_SD_VOL;
		end else begin
			pb_r   <= pb_nxt;
			rec_r  <= rec_nxt;
			prot_r <= prot_nxt;
			sd_r   <= sd_nxt;
		end
	end

	// read port; unmapped offsets answer zero, data holds between reads
	always_comb begin
		rdata_nxt = o_reg_rdata;
		if (i_reg_req.rd) begin
			unique case (i_reg_req.addr)
				amp_cfg_pkg::OFS_PB_SUPPLY: rdata_nxt = pb_r;
				amp_cfg_pkg::OFS_REC_FOLD:  rdata_nxt = rec_r;
				amp_cfg_pkg::OFS_PROT_FB:   rdata_nxt = prot_r;
				amp_cfg_pkg::OFS_SD_VOL:    rdata_nxt = sd_r;
				default:                    rdata_nxt = 8'h00;
			endcase
		end
	end

	// read data flop
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= 8'h00;
		end else begin
			o_reg_rdata <= rdata_nxt;
		end
	end

	// shutdown pin timer
	amp_cfg_pkg::sd_state_t          sd_state_r, sd_state_nxt;
	logic [amp_cfg_pkg::TMO_W-1:0]   tmo_cnt_r, tmo_cnt_nxt;
	logic [amp_cfg_pkg::TMO_W-1:0]   tmo_lim;
	logic                            sd_req_nxt;

	// local copy of the counter width so the size casts name a plain constant;
	// the longest timeout must still fit, so widen it if the clock gets faster
	localparam int TMO_W = amp_cfg_pkg::TMO_W;

	// RQ15 timeout select; a change mid-wait moves the limit at once
	always_comb begin
		unique case (sd_r[amp_cfg_pkg::POS_SD_TMO +: 2])
			2'h0: tmo_lim = TMO_W'(P_CYC_SD0 - 1);
			2'h1: tmo_lim = TMO_W'(P_CYC_SD1 - 1);
			2'h2: tmo_lim = TMO_W'(P_CYC_SD2 - 1);
			2'h3: tmo_lim = TMO_W'(P_CYC_SD3 - 1);
		endcase
	end

	// pin release always returns to run; forced mode skips the wait
	always_comb begin
		sd_state_nxt = sd_state_r;
		tmo_cnt_nxt  = tmo_cnt_r;
		unique case (sd_state_r)
			amp_cfg_pkg::SD_RUN: begin
				tmo_cnt_nxt = '0;
				if (!i_shutdown_pin_n) begin
					// RQ14 immediate or timed
					if (sd_r[amp_cfg_pkg::POS_SD_RESP +: 2] == amp_cfg_pkg::SD_RESP_FORCED) begin
						sd_state_nxt = amp_cfg_pkg::SD_OFF;
					end else begin
						sd_state_nxt = amp_cfg_pkg::SD_WAIT;
					end
				end
			end
			amp_cfg_pkg::SD_WAIT: begin
				if (i_shutdown_pin_n) begin
					sd_state_nxt = amp_cfg_pkg::SD_RUN;
				end else if (tmo_cnt_r >= tmo_lim) begin
					// RQ15 timeout reached
					sd_state_nxt = amp_cfg_pkg::SD_OFF;
				end else begin
					tmo_cnt_nxt = tmo_cnt_r + 1'b1;
				end
			end
			amp_cfg_pkg::SD_OFF: begin
				if (i_shutdown_pin_n) begin
					sd_state_nxt = amp_cfg_pkg::SD_RUN;
				end
			end
			default: sd_state_nxt = amp_cfg_pkg::SD_RUN;
		endcase
		sd_req_nxt = (sd_state_nxt == amp_cfg_pkg::SD_OFF);
	end

	// timer state and counter flops
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sd_state_r <= amp_cfg_pkg::SD_RUN;
			tmo_cnt_r  <= '0;
		end else begin
			sd_state_r <= sd_state_nxt;
			tmo_cnt_r  <= tmo_cnt_nxt;
		end
	end

	// decoded controls, one flop stage so every output is registered;
	// decodes read the next values so outputs change on the write edge itself
	logic        ss_nxt, aux_out_nxt, aux_bo_nxt;
	logic [15:0] scale_nxt;
	logic [4:0]  attn_nxt, oc_pct_nxt;
	logic [3:0]  ramp_nxt;

	always_comb begin
		// RQ4 sync mode overrides spread spectrum
		ss_nxt = pb_nxt[amp_cfg_pkg::BIT_SPREAD] & ~i_classd_sync_en;
		// RQ19 aux supply path follows mode selects
		aux_out_nxt = (i_switch_mode != amp_cfg_pkg::SWMODE_HV_ONLY);
		aux_bo_nxt  = ~i_brownout_src_hv;
		// RQ7 cutoff scale for 44.1 kHz family
		scale_nxt = i_rate_441_family ? amp_cfg_pkg::SCALE_441_Q14 : amp_cfg_pkg::SCALE_UNITY_Q14;
		// RQ12 safe mode attenuation
		attn_nxt = prot_nxt[amp_cfg_pkg::BIT_SAFE_ATTN] ? amp_cfg_pkg::SAFE_ATTN_DB : 5'h00;
		// RQ13 threshold reduction in 10 percent steps
		unique case (prot_nxt[amp_cfg_pkg::POS_OC_THR +: 2])
			2'h0: oc_pct_nxt = 5'h00;
			2'h1: oc_pct_nxt = 5'h0a;
			2'h2: oc_pct_nxt = 5'h14;
			2'h3: oc_pct_nxt = 5'h1e;
		endcase
		// RQ16 samples per half-dB step, zero when disabled
		unique case (sd_nxt[amp_cfg_pkg::POS_RAMP +: 2])
			2'h0: ramp_nxt = 4'h1;
			2'h1: ramp_nxt = 4'h4;
			2'h2: ramp_nxt = 4'h8;
			2'h3: ramp_nxt = 4'h0;
		endcase
	end

	// output flops; all zero in reset, register decodes from the first edge after
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_aux_supply_internal             <= 1'b0;
			o_aux_feeds_output_stage          <= 1'b0;
			o_aux_is_brownout_src             <= 1'b0;
			o_irq_pin_pullup_en               <= 1'b0;
			o_spread_spectrum_active          <= 1'b0;
			o_playback_cutoff_hz              <= 10'h000;
			o_record_cutoff_hz                <= 10'h000;
			o_cutoff_scale_q14                <= 16'h0000;
			o_thermal_foldback_en             <= 1'b0;
			o_overcurrent_auto_retry          <= 1'b0;
			o_overtemp_auto_retry             <= 1'b0;
			o_post_filter_feedback_en         <= 1'b0;
			o_extra_attenuation_db            <= 5'h00;
			o_overcurrent_threshold_below_pct <= 5'h00;
			o_shutdown_req                    <= 1'b0;
			o_volume_ramp_samples             <= 4'h0;
			o_volume_ramp_disabled            <= 1'b0;
			o_broadcast_address_en            <= 1'b0;
			o_target_address_redetect         <= 1'b0;
		end else begin
			// RQ1 aux supply source
			o_aux_supply_internal             <= pb_nxt[amp_cfg_pkg::BIT_AUX_SRC];
			o_aux_feeds_output_stage          <= aux_out_nxt;
			o_aux_is_brownout_src             <= aux_bo_nxt;
			// RQ2 pull-up drive
			o_irq_pin_pullup_en               <= pb_nxt[amp_cfg_pkg::BIT_IRQ_PU];
			// RQ3 spread spectrum gated by sync
			o_spread_spectrum_active          <= ss_nxt;
			// RQ5 RQ6 nominal corners
			o_playback_cutoff_hz              <= cutoff_hz(pb_nxt[amp_cfg_pkg::POS_CUTOFF +: 3]);
			o_record_cutoff_hz                <= cutoff_hz(rec_nxt[amp_cfg_pkg::POS_CUTOFF +: 3]);
			o_cutoff_scale_q14                <= scale_nxt;
			// RQ8 foldback
			o_thermal_foldback_en             <= rec_nxt[amp_cfg_pkg::BIT_FOLDBACK];
			// RQ9 RQ10 retry policy
			o_overcurrent_auto_retry          <= prot_nxt[amp_cfg_pkg::BIT_OC_RETRY];
			o_overtemp_auto_retry             <= prot_nxt[amp_cfg_pkg::BIT_OT_RETRY];
			// RQ11 feedback source
			o_post_filter_feedback_en         <= prot_nxt[amp_cfg_pkg::BIT_PF_FB];
			o_extra_attenuation_db            <= attn_nxt;
			o_overcurrent_threshold_below_pct <= oc_pct_nxt;
			o_shutdown_req                    <= sd_req_nxt;
			o_volume_ramp_samples             <= ramp_nxt;
			o_volume_ramp_disabled            <= (sd_nxt[amp_cfg_pkg::POS_RAMP +: 2] == amp_cfg_pkg::RAMP_OFF);
			// RQ17 broadcast address enable
			o_broadcast_address_en            <= sd_nxt[amp_cfg_pkg::BIT_BCAST];
			// RQ18 re-detect request level
			o_target_address_redetect         <= sd_nxt[amp_cfg_pkg::BIT_REDETECT];
		end
	end

endmodule : amp_dc_block_misc_config
`default_nettype wire

/* test/amp_cfg_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module amp_cfg_sva (
	input wire logic                  i_clk_sys,
	input wire logic                  i_rst,
	input wire amp_cfg_pkg::reg_req_t i_reg_req,
	input wire logic                  i_classd_sync_en,
	input wire logic                  i_rate_441_family,
	input wire logic                  i_shutdown_pin_n,
	input wire logic [7:0]            o_reg_rdata,
	input wire logic                  o_spread_spectrum_active,
	input wire logic [9:0]            o_playback_cutoff_hz,
	input wire logic [15:0]           o_cutoff_scale_q14,
	input wire logic                  o_overcurrent_auto_retry,
	input wire logic                  o_overtemp_auto_retry,
	input wire logic                  o_post_filter_feedback_en,
	input wire logic [4:0]            o_extra_attenuation_db,
	input wire logic [4:0]            o_overcurrent_threshold_below_pct,
	input wire logic                  o_shutdown_req,
	input wire logic [3:0]            o_volume_ramp_samples,
	input wire logic                  o_volume_ramp_disabled,
	input wire logic                  o_target_address_redetect
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	// ramp code to sample interval, zero when ramping is off
	function automatic logic [3:0] ramp_n(input logic [1:0] c);
		return (c == 2'h0) ? 4'h1 : (c == 2'h1) ? 4'h4 : (c == 2'h2) ? 4'h8 : 4'h0;
	endfunction : ramp_n

	// a write strobe aimed at one register
	sequence s_wr(a);
		i_reg_req.wr && i_reg_req.addr == a;
	endsequence

	safe_atten_a : assert property (s_wr(8'h06) |=>
		o_extra_attenuation_db == ($past(i_reg_req.wdata[2]) ? 5'h12 : 5'h00))
		else $error("safe attenuation wrong");
	oc_threshold_a : assert property (s_wr(8'h06) |=>
		o_overcurrent_threshold_below_pct == 5'($past(i_reg_req.wdata[1:0]) * 10))
		else $error("over-current threshold wrong");
	retry_feedback_a : assert property (s_wr(8'h06) |=>
		{o_overcurrent_auto_retry, o_overtemp_auto_retry, o_post_filter_feedback_en}
		== $past(i_reg_req.wdata[5:3])) else $error("retry or feedback bits wrong");
	sync_priority_a : assert property (i_classd_sync_en |=> !o_spread_spectrum_active)
		else $error("spread spectrum active under sync");
	unmapped_read_a : assert property (i_reg_req.rd &&
		(i_reg_req.addr < 8'h04 || i_reg_req.addr > 8'h07) |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	pin_release_a : assert property (i_shutdown_pin_n ##1 i_shutdown_pin_n |->
		!o_shutdown_req) else $error("shutdown held with pin high");
	redetect_set_a : assert property (s_wr(8'h07) ##0 i_reg_req.wdata[0] |=>
		o_target_address_redetect) else $error("re-detect not set");
	ramp_rate_a : assert property (s_wr(8'h07) |=>
		o_volume_ramp_samples == ramp_n($past(i_reg_req.wdata[3:2])) &&
		o_volume_ramp_disabled == ($past(i_reg_req.wdata[3:2]) == 2'h3))
		else $error("ramp decode wrong");
	cutoff_rsvd_a : assert property (s_wr(8'h04) ##0 i_reg_req.wdata[2:0] == 3'h7 |=>
		$stable(o_playback_cutoff_hz)) else $error("reserved cutoff took effect");
	rate_scale_a : assert property (1'b1 |=> o_cutoff_scale_q14 ==
		($past(i_rate_441_family) ? 16'h3acd : 16'h4000)) else $error("cutoff scale wrong");
endmodule : amp_cfg_sva
`default_nettype wire

/* test/amp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// register host: drives just after falling edges, holds one full cycle
module amp_host_model (
	input  wire logic                  i_clk_sys,
	input  wire logic [7:0]            i_reg_rdata,
	output var  amp_cfg_pkg::reg_req_t o_req
);
	initial o_req = '0;

	// idle bus shows inverted values so stale data is never trusted
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk_sys);
		o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge i_clk_sys);
		o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : wr

	// read data is registered on the edge that takes the strobe and sampled at the next falling edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk_sys);
		o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge i_clk_sys);
		o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		d = i_reg_rdata;
	endtask : rd

	task automatic redetect();
		wr(8'h07, 8'h01);
	endtask : redetect
endmodule : amp_host_model
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, rst, sync, rate, bo, pin, done;
	logic [1:0] sw;
	logic [7:0] d;
	amp_cfg_pkg::reg_req_t req;
	logic [7:0] rdata;
	logic aux_int, feeds, bo_src, pu, spread, fold, ocr, otr, pf, req_sd, rdis, bc, rdt;
	logic [9:0] pb_hz, rec_hz;
	logic [15:0] scale;
	logic [4:0] attn, pct;
	logic [3:0] rsmp;
	int failures, tests_run, n;
	typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} row_t;
	row_t rows[9] = '{'{8'h04, 8'hff, 8'he1}, '{8'h04, 8'h16, 8'h06}, '{8'h05, 8'hf5, 8'hf5},
		'{8'h05, 8'h0f, 8'h0d}, '{8'h06, 8'h3f, 8'h3f}, '{8'h06, 8'hc4, 8'hc4},
		'{8'h07, 8'h5e, 8'h5e}, '{8'h07, 8'h9c, 8'h5c}, '{8'h07, 8'h08, 8'h08}};
	logic [7:0] rst_v[4] = '{8'h21, 8'h41, 8'h00, 8'h20};
	logic [9:0] hz[7] = '{10'd0, 10'd2, 10'd50, 10'd100, 10'd200, 10'd400, 10'd800};

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	amp_host_model h_u (.i_clk_sys(clk), .i_reg_rdata(rdata), .o_req(req));
	amp_dc_block_misc_config #(.P_CYC_SD0(4), .P_CYC_SD1(8), .P_CYC_SD2(12), .P_CYC_SD3(20))
	dut_u (.i_clk_sys(clk), .i_rst(rst), .i_reg_req(req), .i_classd_sync_en(sync),
		.i_rate_441_family(rate), .i_switch_mode(sw), .i_brownout_src_hv(bo),
		.i_shutdown_pin_n(pin), .i_address_detect_done(done), .o_reg_rdata(rdata),
		.o_aux_supply_internal(aux_int), .o_aux_feeds_output_stage(feeds),
		.o_aux_is_brownout_src(bo_src), .o_irq_pin_pullup_en(pu),
		.o_spread_spectrum_active(spread), .o_playback_cutoff_hz(pb_hz),
		.o_record_cutoff_hz(rec_hz), .o_cutoff_scale_q14(scale), .o_thermal_foldback_en(fold),
		.o_overcurrent_auto_retry(ocr), .o_overtemp_auto_retry(otr),
		.o_post_filter_feedback_en(pf), .o_extra_attenuation_db(attn),
		.o_overcurrent_threshold_below_pct(pct), .o_shutdown_req(req_sd),
		.o_volume_ramp_samples(rsmp), .o_volume_ramp_disabled(rdis),
		.o_broadcast_address_en(bc), .o_target_address_redetect(rdt));

	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic test_done();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	// watchdog far beyond the fewer than two hundred cycles the sequence needs
	initial begin
		#200000;
		failures++;
		test_done();
	end

	initial begin
		{rst, sync, rate, bo, pin, done, sw} = {1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0};
		repeat (16) @(negedge clk);
		rst = 1'b0;
		foreach (rst_v[i]) begin
			h_u.rd(8'h04 + 8'(i), d);
			chk("reset value", d, rst_v[i]);
		end
		h_u.wr(8'h08, 8'hff);
		h_u.rd(8'h08, d);
		chk("unmapped", d, 8'h00);
		// write and read back each row; reserved codes must not stick
		foreach (rows[i]) begin
			h_u.wr(rows[i].a, rows[i].w);
			h_u.rd(rows[i].a, d);
			chk("readback", d, rows[i].r);
		end
		for (int c = 0; c < 7; c++) begin
			h_u.wr(8'h04, 8'(c));
			h_u.wr(8'h05, 8'(c));
			h_u.wr(8'h06, 8'(c));
			chk("playback cutoff", pb_hz, hz[c]);
			chk("record cutoff", rec_hz, hz[c]);
			chk("safe atten", attn, (c >= 4) ? 16'h0012 : 16'h0000);
			chk("oc threshold", pct, 16'((c % 4) * 10));
		end
		h_u.wr(8'h05, 8'h08);
		chk("foldback", fold, 1'b1);
		h_u.wr(8'h04, 8'he1);
		chk("aux and pull-up", {aux_int, pu, spread}, 3'h7);
		@(negedge clk) {sync, rate, sw, bo} = {1'b1, 1'b1, 2'h2, 1'b0};
		@(negedge clk);
		@(negedge clk);
		chk("sync wins", spread, 1'b0);
		chk("scaled", scale, 16'h3acd);
		chk("aux use", {feeds, bo_src}, 2'h1);
		h_u.wr(8'h07, 8'h02);
		chk("broadcast", bc, 1'b1);
		h_u.redetect();
		h_u.rd(8'h07, d);
		chk("redetect set", d, 8'h01);
		@(negedge clk) done = 1'b1;
		@(negedge clk) done = 1'b0;
		h_u.rd(8'h07, d);
		chk("redetect clear", d, 8'h00);
		chk("redetect out", rdt, 1'b0);
		// short low pulse in timed mode must abort the wait
		@(negedge clk) pin = 1'b0;
		@(negedge clk);
		@(negedge clk) pin = 1'b1;
		n = 0;
		repeat (12) @(negedge clk) n += int'(req_sd === 1'b1);
		chk("abort", 16'(n), 16'h0);
		@(negedge clk) pin = 1'b0;
		n = 0;
		while (req_sd !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk("timed shutdown", 16'(n >= 4 && n <= 7), 16'h1);
		@(negedge clk) pin = 1'b1;
		h_u.wr(8'h07, 8'h40);
		@(negedge clk) pin = 1'b0;
		@(negedge clk);
		@(negedge clk);
		chk("forced shutdown", req_sd, 1'b1);
		@(negedge clk) {pin, rst} = 2'h3;
		@(negedge clk) rst = 1'b0;
		h_u.rd(8'h04, d);
		chk("second reset", d, 8'h21);
		test_done();
	end
endmodule : testbench

bind amp_dc_block_misc_config amp_cfg_sva chk_u (.i_clk_sys, .i_rst, .i_reg_req,
	.i_classd_sync_en, .i_rate_441_family, .i_shutdown_pin_n, .o_reg_rdata,
	.o_spread_spectrum_active, .o_playback_cutoff_hz, .o_cutoff_scale_q14,
	.o_overcurrent_auto_retry, .o_overtemp_auto_retry, .o_post_filter_feedback_en,
	.o_extra_attenuation_db, .o_overcurrent_threshold_below_pct, .o_shutdown_req,
	.o_volume_ramp_samples, .o_volume_ramp_disabled, .o_target_address_redetect);
`default_nettype wire
